// ==== ext_counter_pkg.sv ====
package ext_counter_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_GLOBAL_CTRL = 8'h0b;
  localparam logic [7:0] IDX_FLAGS_ONE   = 8'h0c;
  localparam logic [7:0] IDX_COUNT_LOW   = 8'h0e;
  localparam logic [7:0] IDX_COUNT_HIGH  = 8'h0f;
  localparam logic [7:0] IDX_CONTROL     = 8'h10;
  localparam logic [7:0] IDX_ENABLES_ONE = 8'h8c;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned GLOBAL_IRQ_ENABLE_BIT     = 7;
  localparam int unsigned PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int unsigned OVERFLOW_FLAG_BIT         = 0;
  localparam int unsigned OVERFLOW_IRQ_EN_BIT       = 0;

  localparam logic [7:0]  GLOBAL_CTRL_RST = 8'h00;
  localparam logic [7:0]  FLAGS_ONE_RST   = 8'h00;
  localparam logic [7:0]  ENABLES_ONE_RST = 8'h00;
  localparam logic [7:0]  CONTROL_RST     = 8'h00;
  localparam logic [15:0] COUNT_CLEAR     = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES  = 16'hffff;

  // ----------------------------------------------------------------
  // Modes and timing
  // ----------------------------------------------------------------
  localparam logic [3:0]  CCP_TRIGGER_MODE = 4'hb;
  localparam int unsigned INSTR_DIV        = 4;
  localparam logic [1:0]  INSTR_DIV_LAST   = 2'(INSTR_DIV - 1);
  localparam int unsigned OSC_MAX_KHZ      = 200;
  localparam int unsigned PRESC_W          = 3;

  // Prescale select code to mask of prescaler bits that must all be one
  localparam logic [PRESC_W-1:0] PRESC_MASK [4] = '{3'h0, 3'h1, 3'h3, 3'h7};

  typedef struct packed {
    logic [1:0] reserved;
    logic [1:0] input_prescale_select;
    logic       osc_enable;
    logic       sync_disable_n;
    logic       clock_source_select;
    logic       counter_run;
  } counter_control_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
    logic [3:0]        byteenable;
  } avalon_req_t;

endpackage : ext_counter_pkg

// ==== ext_counter.sv ====
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module ext_counter
  import ext_counter_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              por_bor_i,
  input  wire logic              sleep_i,
  input  wire logic [ADDR_W-1:0] address_i,
  input  wire logic              read_i,
  input  wire logic              write_i,
  input  wire logic [DATA_W-1:0] writedata_i,
  input  wire logic [3:0]        byteenable_i,
  output logic      [DATA_W-1:0] readdata_o,
  output logic                   waitrequest_o,
  input  wire logic              ext_clock_pin_i,
  input  wire logic              osc_in_pin_i,
  output logic                   osc_out_pin_o,
  output logic                   osc_amp_en_o,
  input  wire logic [1:0]        ccp_trigger_i,
  input  wire logic [3:0]        ccp1_mode_select_i,
  input  wire logic [3:0]        ccp2_mode_select_i,
  output logic      [15:0]       count_o,
  output logic                   timebase_valid_o,
  output logic                   irq_o,
  output logic                   wake_o
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  avalon_req_t req;
  assign req = '{address: address_i, read: read_i, write: write_i,
                 writedata: writedata_i, byteenable: byteenable_i};

  logic       wait_q;
  logic       wait_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  wire        req_any    = req.read | req.write;
  wire  [7:0] reg_idx    = req.address[ADDR_W-1:2];
  wire        wr_commit  = req.write & ~wait_q & req.byteenable[0];
  wire  [7:0] wbyte      = req.writedata[7:0];
  wire        wr_global  = wr_commit & (reg_idx == IDX_GLOBAL_CTRL);
  wire        wr_flags   = wr_commit & (reg_idx == IDX_FLAGS_ONE);
  wire        wr_cnt_lo  = wr_commit & (reg_idx == IDX_COUNT_LOW);
  wire        wr_cnt_hi  = wr_commit & (reg_idx == IDX_COUNT_HIGH);
  wire        wr_control = wr_commit & (reg_idx == IDX_CONTROL);
  wire        wr_enables = wr_commit & (reg_idx == IDX_ENABLES_ONE);
  wire        wr_count   = wr_cnt_lo | wr_cnt_hi;

  // Every access waits one cycle so read data comes from a flop
  assign wait_d = ~(req_any & wait_q);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= wait_d;
    end
  end

  // Captured every cycle; only the answer cycle matters to the master
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign waitrequest_o = wait_q;
  assign readdata_o    = {{(DATA_W-8){1'b0}}, rdata_q};

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  counter_control_t ctrl_q;
  counter_control_t ctrl_d;
  logic [7:0]       global_q;
  logic [7:0]       flags_q;
  logic [7:0]       flags_d;
  logic [7:0]       enables_q;
  logic [15:0]      count_q;
  logic [15:0]      count_d;
  logic             overflow_evt;

  wire ctrl_run   = ctrl_q.counter_run;
  wire ext_mode   = ctrl_q.clock_source_select;
  wire async_mode = ext_mode & ctrl_q.sync_disable_n;

  // Reserved bits never store a one
  always_comb begin
    ctrl_d          = ctrl_q;
    if (wr_control) begin
      ctrl_d          = counter_control_t'(wbyte);
      ctrl_d.reserved = 2'b00;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = wbyte;
    end
    if (overflow_evt) begin
      flags_d[OVERFLOW_FLAG_BIT] = 1'b1;
    end
  end

  // Control survives ordinary resets; cleared only on power-on or brown-out
  always_ff @(posedge clk_i) begin
    if (srst_i && por_bor_i) begin
      ctrl_q <= counter_control_t'(CONTROL_RST);
    end else if (!srst_i) begin
      ctrl_q <= ctrl_d;
    end
  end

  // Only the overflow bits and the two interrupt enable bits have hardware behind them; the rest is storage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      global_q <= GLOBAL_CTRL_RST;
    end else if (wr_global) begin
      global_q <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flags_q <= FLAGS_ONE_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      enables_q <= ENABLES_ONE_RST;
    end else if (wr_enables) begin
      enables_q <= wbyte;
    end
  end

  // Count bytes read straight from the sampled-domain count flops
  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_idx)
      IDX_GLOBAL_CTRL: rdata_d = global_q;
      IDX_FLAGS_ONE:   rdata_d = flags_q;
      IDX_COUNT_LOW:   rdata_d = count_q[7:0];
      IDX_COUNT_HIGH:  rdata_d = count_q[15:8];
      IDX_CONTROL:     rdata_d = ctrl_q;
      IDX_ENABLES_ONE: rdata_d = enables_q;
      default:         rdata_d = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;

  always_ff @(posedge clk_i) begin
    pin_meta_q <= {osc_in_pin_i, ext_clock_pin_i};
    pin_sync_q <= pin_meta_q;
  end

  wire osc_in_s  = pin_sync_q[1];
  wire ext_clk_s = pin_sync_q[0];

  // ----------------------------------------------------------------
  // Oscillator amplifier
  // ----------------------------------------------------------------
  // Sleep does not gate the amplifier, so the crystal keeps running
  logic osc_out_q;
  logic osc_en_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_en_q <= 1'b0;
    end else begin
      osc_en_q <= ctrl_q.osc_enable;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_out_q <= 1'b0;
    end else begin
      osc_out_q <= ctrl_q.osc_enable & ~osc_in_s;
    end
  end

  assign osc_amp_en_o  = osc_en_q;
  assign osc_out_pin_o = osc_out_q;

  // ----------------------------------------------------------------
  // Input selection and edge detection
  // ----------------------------------------------------------------
  logic prev_in_q;
  logic armed_q;
  logic armed_d;
  logic [1:0] instr_div_q;

  wire ext_in     = ctrl_q.osc_enable ? osc_in_s : ext_clk_s;
  wire ext_rise   = ext_in & ~prev_in_q;
  wire ext_fall   = ~ext_in & prev_in_q;
  wire instr_tick = (instr_div_q == INSTR_DIV_LAST) & ~sleep_i;

  // A freshly enabled counter input waits for one falling edge
  always_comb begin
    armed_d = armed_q;
    if (!ctrl_run || !ext_mode) begin
      armed_d = 1'b0;
    end else if (ext_fall) begin
      armed_d = 1'b1;
    end
  end

  // Resets low to match the idle pin, so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prev_in_q <= 1'b0;
    end else begin
      prev_in_q <= ext_in;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
    end
  end

  // Free-running, so the first timer tick after run may come early
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      instr_div_q <= 2'b00;
    end else begin
      instr_div_q <= instr_div_q + 2'b01;
    end
  end

  // Sync bit plays no part when counting the instruction clock
  wire src_edge = ext_mode ? (ext_rise & armed_q) : instr_tick;

  // ----------------------------------------------------------------
  // Ripple prescaler
  // ----------------------------------------------------------------
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] presc_toggle;

  // Each stage toggles when all lower stages roll over, as a ripple chain
  for (genvar i = 0; i < PRESC_W; i++) begin : g_ripple
    if (i == 0) begin : g_first
      assign presc_toggle[i] = src_edge & ctrl_run;
    end else begin : g_next
      assign presc_toggle[i] = presc_toggle[i-1] & presc_q[i-1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || wr_count) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q ^ presc_toggle;
    end
  end

  wire [PRESC_W-1:0] presc_mask = PRESC_MASK[ctrl_q.input_prescale_select];
  wire presc_tick = presc_toggle[0] & ((presc_q & presc_mask) == presc_mask);

  // ----------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------
  // Synchronised path is shut off in sleep; unsynchronised path is not
  wire sync_gate = async_mode | ~sleep_i;
  wire count_inc = presc_tick & ctrl_run & sync_gate;

  wire trig1 = ccp_trigger_i[0] & (ccp1_mode_select_i == CCP_TRIGGER_MODE);
  wire trig2 = ccp_trigger_i[1] & (ccp2_mode_select_i == CCP_TRIGGER_MODE);
  // Trigger is dropped in unsynchronised mode rather than risk a torn count
  wire trig_reset = (trig1 | trig2) & ~async_mode;

  always_comb begin
    count_d      = count_q;
    overflow_evt = 1'b0;
    if (wr_count) begin
      // Software write wins over trigger and increment
      if (wr_cnt_lo) begin
        count_d[7:0] = wbyte;
      end
      if (wr_cnt_hi) begin
        count_d[15:8] = wbyte;
      end
    end else if (trig_reset) begin
      // Compare unit matches count_o, so its pair becomes the period
      count_d = COUNT_CLEAR;
    end else if (count_inc) begin
      count_d      = count_q + 16'h0001;
      overflow_evt = (count_q == COUNT_ALL_ONES);
    end
  end

  // No reset branch: the count keeps its value through every reset
  always_ff @(posedge clk_i) begin
    count_q <= count_d;
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  logic tb_valid_q;
  logic irq_q;
  logic wake_q;
  logic [15:0] count_out_q;

  wire ovf_pending = flags_q[OVERFLOW_FLAG_BIT] & enables_q[OVERFLOW_IRQ_EN_BIT];
  wire irq_gates   = global_q[GLOBAL_IRQ_ENABLE_BIT] & global_q[PERIPHERAL_IRQ_ENABLE_BIT];

  // Capture and compare must not trust an unsynchronised count
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tb_valid_q <= 1'b0;
    end else begin
      tb_valid_q <= ~async_mode;
    end
  end

  // Mirrors the next count so compare logic sees it without lag
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_out_q <= COUNT_CLEAR;
    end else begin
      count_out_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and wake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ovf_pending & irq_gates;
    end
  end

  // Wake ignores the global enables so a masked overflow still ends sleep
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= ovf_pending & sleep_i;
    end
  end

  assign timebase_valid_o = tb_valid_q;
  assign irq_o            = irq_q;
  assign wake_o           = wake_q;
  assign count_o          = count_out_q;

endmodule : ext_counter
`default_nettype wire

// ==== ext_counter_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module ext_counter_chk
  import ext_counter_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              srst_i,
  input wire logic              sleep_i,
  input wire logic              read_i,
  input wire logic              write_i,
  input wire logic [1:0]        ccp_trigger_i,
  input wire logic [3:0]        ccp1_mode_select_i,
  input wire logic [3:0]        ccp2_mode_select_i,
  input wire logic [DATA_W-1:0] readdata_o,
  input wire logic              waitrequest_o,
  input wire logic              osc_out_pin_o,
  input wire logic              osc_amp_en_o,
  input wire logic [15:0]       count_o,
  input wire logic              timebase_valid_o,
  input wire logic              irq_o,
  input wire logic              wake_o
);
  wire logic trig_w = (ccp_trigger_i[0] && ccp1_mode_select_i == CCP_TRIGGER_MODE)
                   || (ccp_trigger_i[1] && ccp2_mode_select_i == CCP_TRIGGER_MODE);
  // Steps are judged only away from writes and triggers
  wire logic quiet_w = !write_i && !trig_w;

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // ------
  // Bus
  // ------
  a_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("wait low too long");
  a_wait_idle: assert property (!(read_i || write_i) |=> waitrequest_o)
    else $error("wait low without request");
  a_wait_answer: assert property ($rose(read_i || write_i) |=> !waitrequest_o)
    else $error("no answer");
  a_upper_zero: assert property (!waitrequest_o |-> readdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  // ------
  // Count
  // ------
  a_count_step: assert property (
    count_o != $past(count_o) && $past(quiet_w) && $past(quiet_w, 2) && !$past(srst_i, 2)
    |-> count_o == $past(count_o) + 16'h1) else $error("count jumped");
  a_incr_gap: assert property (
    count_o == $past(count_o) + 16'h1 && quiet_w && !$past(srst_i, 2) |=> $stable(count_o))
    else $error("increments too close");
  a_trig_reset: assert property (
    trig_w && timebase_valid_o && !write_i && !$past(write_i) |-> ##[1:2] count_o == COUNT_CLEAR)
    else $error("trigger did not clear count");
  a_sleep_hold: assert property (
    sleep_i && $past(sleep_i) && timebase_valid_o && quiet_w |=> $stable(count_o))
    else $error("count moved in sleep");
  a_wake_sleep: assert property (wake_o |-> $past(sleep_i))
    else $error("wake outside sleep");
  a_osc_gated: assert property (osc_out_pin_o |-> osc_amp_en_o)
    else $error("oscillator output while off");

  c_trigger: cover property (trig_w && timebase_valid_o);
  c_wake: cover property ($rose(wake_o));
  c_irq: cover property ($rose(irq_o));
endmodule : ext_counter_chk

bind ext_counter ext_counter_chk u_chk (
  .clk_i              (clk_i),
  .srst_i             (srst_i),
  .sleep_i            (sleep_i),
  .read_i             (read_i),
  .write_i            (write_i),
  .ccp_trigger_i      (ccp_trigger_i),
  .ccp1_mode_select_i (ccp1_mode_select_i),
  .ccp2_mode_select_i (ccp2_mode_select_i),
  .readdata_o         (readdata_o),
  .waitrequest_o      (waitrequest_o),
  .osc_out_pin_o      (osc_out_pin_o),
  .osc_amp_en_o       (osc_amp_en_o),
  .count_o            (count_o),
  .timebase_valid_o   (timebase_valid_o),
  .irq_o              (irq_o),
  .wake_o             (wake_o)
);
`default_nettype wire

// ==== ext_counter_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ext_counter_tb_top
  import ext_counter_pkg::*;
;
  logic              clk_i = 1'b0;
  logic              srst_i = 1'b1;
  logic              por_bor_i = 1'b1;
  logic              sleep_i = 1'b0;
  logic [ADDR_W-1:0] address_i = '0;
  logic              read_i = 1'b0;
  logic              write_i = 1'b0;
  logic [DATA_W-1:0] writedata_i = '0;
  logic [3:0]        byteenable_i = 4'hf;
  logic              ext_clock_pin_i = 1'b0;
  logic              osc_in_pin_i = 1'b0;
  logic [1:0]        ccp_trigger_i = 2'h0;
  logic [3:0]        ccp1_mode_select_i = 4'hb;
  logic [3:0]        ccp2_mode_select_i = 4'hb;
  logic [DATA_W-1:0] readdata_o;
  logic [15:0]       count_o;
  logic              waitrequest_o;
  logic              osc_out_pin_o;
  logic              osc_amp_en_o;
  logic              timebase_valid_o;
  logic              irq_o;
  logic              wake_o;
  logic [7:0]        rd;
  logic [7:0]        cfg;
  logic [15:0]       c;
  int                n;
  int                bad_count = 0;
  int                total_checks = 0;
  logic [7:0]        ridx [5] = '{IDX_GLOBAL_CTRL, IDX_FLAGS_ONE, IDX_CONTROL, IDX_ENABLES_ONE, 8'h11};

  ext_counter DUT (
    .clk_i              (clk_i),
    .srst_i             (srst_i),
    .por_bor_i          (por_bor_i),
    .sleep_i            (sleep_i),
    .address_i          (address_i),
    .read_i             (read_i),
    .write_i            (write_i),
    .writedata_i        (writedata_i),
    .byteenable_i       (byteenable_i),
    .readdata_o         (readdata_o),
    .waitrequest_o      (waitrequest_o),
    .ext_clock_pin_i    (ext_clock_pin_i),
    .osc_in_pin_i       (osc_in_pin_i),
    .osc_out_pin_o      (osc_out_pin_o),
    .osc_amp_en_o       (osc_amp_en_o),
    .ccp_trigger_i      (ccp_trigger_i),
    .ccp1_mode_select_i (ccp1_mode_select_i),
    .ccp2_mode_select_i (ccp2_mode_select_i),
    .count_o            (count_o),
    .timebase_valid_o   (timebase_valid_o),
    .irq_o              (irq_o),
    .wake_o             (wake_o)
  );

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // ------
  // Drivers
  // ------
  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    address_i <= {idx, 2'b00};
    write_i <= wr;
    read_i <= !wr;
    writedata_i <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (waitrequest_o !== 1'b0 && k < 40);
    if (k >= 40) begin
      bad_count++;
      final_report();
    end
    rd = readdata_o[7:0];
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask : bus

  task automatic setcnt(input logic [15:0] v);
    bus(1'b1, IDX_COUNT_LOW, v[7:0]);
    bus(1'b1, IDX_COUNT_HIGH, v[15:8]);
  endtask : setcnt

  task automatic getcnt(output logic [15:0] v);
    bus(1'b0, IDX_COUNT_LOW, 8'h00);
    v[7:0] = rd;
    bus(1'b0, IDX_COUNT_HIGH, 8'h00);
    v[15:8] = rd;
  endtask : getcnt

  // Edges four cycles apart so the input synchroniser never misses one
  task automatic pulse(input logic osc, input int cnt);
    repeat (cnt) begin
      repeat (4) @(posedge clk_i);
      if (osc) osc_in_pin_i <= 1'b1; else ext_clock_pin_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      if (osc) osc_in_pin_i <= 1'b0; else ext_clock_pin_i <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
  endtask : pulse

  task automatic do_reset(input logic por);
    @(posedge clk_i);
    srst_i <= 1'b1;
    por_bor_i <= por;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    por_bor_i <= 1'b0;
  endtask : do_reset

  task automatic wait_chg(output int k);
    logic [15:0] v;
    v = count_o;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (count_o === v && k < 50);
    if (count_o === v) begin
      bad_count++;
      final_report();
    end
  endtask : wait_chg

  // ------
  // Scenarios
  // ------
  initial begin
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    por_bor_i <= 1'b0;
    foreach (ridx[i]) begin
      bus(1'b0, ridx[i], 8'h00);
      chk("reset value", 16'h0000, {8'h0, rd});
    end
    bus(1'b1, IDX_CONTROL, 8'hff);
    bus(1'b0, IDX_CONTROL, 8'h00);
    chk("control bits", 16'h003f, {8'h0, rd});
    bus(1'b1, IDX_CONTROL, 8'h30);
    setcnt(16'h1234);
    do_reset(1'b0);
    bus(1'b0, IDX_CONTROL, 8'h00);
    chk("control kept", 16'h0030, {8'h0, rd});
    do_reset(1'b1);
    bus(1'b0, IDX_CONTROL, 8'h00);
    chk("control cleared", 16'h0000, {8'h0, rd});
    getcnt(c);
    chk("count kept", 16'h1234, c);
    for (int i = 0; i < 5; i++) begin
      n = (i < 4) ? 3 - i : 0;
      cfg = (i < 4) ? {2'b00, 2'(n), 4'h3} : 8'h0b;
      bus(1'b1, IDX_CONTROL, 8'h02);
      setcnt(16'h0000);
      bus(1'b1, IDX_CONTROL, cfg);
      if (i == 4) repeat (16) @(posedge clk_i);
      pulse(i == 4, 19);
      getcnt(c);
      chk("edges counted", 16'(18 >> n), c);
    end
    chk("osc amplifier", 16'h0001, {15'h0, osc_amp_en_o});
    chk("osc output", 16'h0001, {15'h0, osc_out_pin_o});
    chk("sync time base", 16'h0001, {15'h0, timebase_valid_o});
    bus(1'b1, IDX_CONTROL, 8'h01);
    wait_chg(n);
    wait_chg(n);
    chk("timer step", 16'h0004, 16'(n));
    for (int i = 0; i < 3; i++) begin
      ccp1_mode_select_i <= (i == 2) ? 4'ha : 4'hb;
      bus(1'b1, IDX_CONTROL, 8'h00);
      setcnt(16'h1000);
      bus(1'b1, IDX_CONTROL, 8'h01);
      @(posedge clk_i);
      ccp_trigger_i <= (i == 1) ? 2'h2 : 2'h1;
      @(posedge clk_i);
      ccp_trigger_i <= 2'h0;
      repeat (3) @(posedge clk_i);
      chk("trigger kept count", 16'(i == 2), 16'(count_o >= 16'h1000));
    end
    bus(1'b0, IDX_FLAGS_ONE, 8'h00);
    chk("flag after trigger", 16'h0000, {8'h0, rd});
    ccp1_mode_select_i <= 4'hb;
    bus(1'b1, IDX_CONTROL, 8'h00);
    ccp_trigger_i <= 2'h1;
    bus(1'b1, IDX_COUNT_LOW, 8'h5a);
    ccp_trigger_i <= 2'h0;
    bus(1'b0, IDX_COUNT_LOW, 8'h00);
    chk("write over trigger", 16'h005a, {8'h0, rd});
    bus(1'b1, IDX_CONTROL, 8'h02);
    setcnt(16'h0000);
    bus(1'b1, IDX_CONTROL, 8'h03);
    sleep_i <= 1'b1;
    pulse(1'b0, 4);
    sleep_i <= 1'b0;
    pulse(1'b0, 4);
    getcnt(c);
    chk("sleep hold", 16'h0004, c);
    bus(1'b1, IDX_CONTROL, 8'h06);
    setcnt(16'hffff);
    bus(1'b1, IDX_ENABLES_ONE, 8'h01);
    bus(1'b1, IDX_CONTROL, 8'h07);
    sleep_i <= 1'b1;
    pulse(1'b0, 3);
    chk("wake", 16'h0001, {15'h0, wake_o});
    chk("masked irq", 16'h0000, {15'h0, irq_o});
    chk("async time base", 16'h0000, {15'h0, timebase_valid_o});
    sleep_i <= 1'b0;
    getcnt(c);
    chk("async count", 16'h0001, c);
    bus(1'b0, IDX_FLAGS_ONE, 8'h00);
    chk("overflow flag", 16'h0001, {8'h0, rd});
    bus(1'b1, IDX_GLOBAL_CTRL, 8'hc0);
    repeat (2) @(posedge clk_i);
    chk("irq", 16'h0001, {15'h0, irq_o});
    bus(1'b1, IDX_FLAGS_ONE, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 16'h0000, {15'h0, irq_o});
    ccp_trigger_i <= 2'h1;
    @(posedge clk_i);
    ccp_trigger_i <= 2'h0;
    repeat (3) @(posedge clk_i);
    chk("async trigger ignored", 16'h0001, count_o);
    final_report();
  end
endmodule : ext_counter_tb_top
`default_nettype wire
